// ===== hdl/sram_port.sv
// Pipelined burst SRAM core with common data and parity bus.
// Assumes the memory controller drives all synchronous inputs from clk_in.
//
// Overview of operation
// - High clock qualifier freezes the access pipeline; sleep and strap logic still run.
// - Inputs captured and outputs registered on rising edge.
// - Selected edge with load latches the address.
// - Selected load with write select high reads.
// - Read data driven after the following edge.
// - Output enable and internal control gate drivers.
// - New command accepted right after a read.
// - Deselect floats outputs after the next edge.
// - Burst counter gives four accesses per load.
// - Strap picks linear or interleaved, low bits wrap.
// - Advance steps counter regardless of selects.
// - Write select held for whole burst.
// - Selected load with write select low writes.
// - Bus floats at edge after write command.
// - Write data captured two edges after command.
// - Only selected byte lanes are stored.
// - Sleep input enters retained low-power state.
// - Select needs first, third low, second high.
// - Outputs float first clock after deselect.
// - Parity bits follow their own lane select.
// - Interleave XORs step, linear adds modulo four.
`timescale 1ns/1ps
`default_nettype none

module sram_port
(
   input  wire logic                                 clk_in,
   input  wire logic                                 rst_in,
   input  wire sram_port_pkg::ctrl_t                 ctrl_in,
   input  wire logic                                 out_drive_en_n_in,
   input  wire logic                                 burst_order_in,
   input  wire logic                                 sleep_request_in,
   input  wire logic [sram_port_pkg::DATA_W-1:0]     data_in,
   output logic      [sram_port_pkg::DATA_W-1:0]     data_out,
   output logic                                      data_oe_out,
   output logic                                      asleep_out
);

   ////////////////////////////////////////////////////////////////////////////

   // Returns the two low address bits of a burst step.
   function automatic logic [1:0] burst_low
   (
      input logic [1:0] start,
      input logic [1:0] step,
      input logic       order
   );
      logic [1:0] result;
      if (order == sram_port_pkg::ORDER_INTERLEAVED)
      begin
         result = start ^ step;
      end
      else
      begin
         result = start + step;
      end
      return result;
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   // Returns one nine-bit byte lane of a bus word.
   function automatic logic [sram_port_pkg::LANE_W-1:0] lane_slice
   (
      input logic [sram_port_pkg::DATA_W-1:0] word,
      input int                               pos
   );
      return word[pos*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   // Returns high when all three chip selects are active.
   function automatic logic is_selected
   (
      input sram_port_pkg::ctrl_t ctrl
   );
      return ~ctrl.chip_sel_first_n & ctrl.chip_sel_second & ~ctrl.chip_sel_third_n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   sram_port_pkg::state_t                   s;
   sram_port_pkg::state_t                   next_s;
   logic [sram_port_pkg::DATA_W-1:0]        read_word;
   logic                                    selected;
   logic [1:0]                              next_step;
   logic                                    commit;

   assign selected = is_selected(ctrl_in);

   assign commit = ~ctrl_in.clk_qualify_n & s.wr.valid
                   & (s.power != sram_port_pkg::PWR_ASLEEP);

   assign next_step = s.step + sram_port_pkg::BURST_STEP_ONE;

   ////////////////////////////////////////////////////////////////////////////

   // One storage array per lane; each lane holds eight data bits and parity.
   // Four nine-bit lanes
   genvar lane;
   generate
      for (lane = 0; lane < sram_port_pkg::LANE_COUNT; lane = lane + 1)
      begin : g_lane
         logic [sram_port_pkg::LANE_W-1:0] lane_mem [0:sram_port_pkg::DEPTH-1];
         logic                             bypass;

         always_ff @(posedge clk_in)
         begin
            if (commit && !s.wr.lanes_n[lane])
            begin
               lane_mem[s.wr.addr] <= lane_slice(data_in, lane);
            end
         end

         // A read right behind a write to the same word sees the new data.
         assign bypass = commit & ~s.wr.lanes_n[lane] & (s.wr.addr == s.cmd.addr);

         assign read_word[lane*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] =
            bypass ? lane_slice(data_in, lane) : lane_mem[s.cmd.addr];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      next_s = s;

      // The burst-order strap is caught on the first edge after reset.
      if (!s.order_taken)
      begin
         next_s.order       = burst_order_in;
         next_s.order_taken = 1'b1;
      end

      case (s.power)
         sram_port_pkg::PWR_AWAKE:
         begin
            if (sleep_request_in)
            begin
               next_s.power     = sram_port_pkg::PWR_ENTERING;
               next_s.sleep_cnt = 2'h1;
            end
         end
         sram_port_pkg::PWR_ENTERING:
         begin
            if (!sleep_request_in)
            begin
               next_s.power = sram_port_pkg::PWR_AWAKE;
            end
            else if (s.sleep_cnt == sram_port_pkg::SLEEP_ENTRY_CYCLES - 2'h1)
            begin
               next_s.power  = sram_port_pkg::PWR_ASLEEP;
               next_s.asleep = 1'b1;
            end
            else
            begin
               next_s.sleep_cnt = s.sleep_cnt + 2'h1;
            end
         end
         sram_port_pkg::PWR_ASLEEP:
         begin
            if (!sleep_request_in)
            begin
               next_s.power  = sram_port_pkg::PWR_AWAKE;
               next_s.asleep = 1'b0;
            end
         end
         default:
         begin
            next_s.power = sram_port_pkg::PWR_AWAKE;
         end
      endcase

      if (s.power == sram_port_pkg::PWR_ASLEEP)
      begin
         // Pending accesses are dropped; stored data is kept.
         next_s.cmd        = '0;
         next_s.wr         = '0;
         next_s.drive      = 1'b0;
         next_s.burst_live = 1'b0;
      end
      else if (!ctrl_in.clk_qualify_n)
      begin
         // Drive only after a read stage
         next_s.drive = s.cmd.valid & ~s.cmd.write;
         next_s.dout  = read_word;
         next_s.wr    = (s.cmd.valid && s.cmd.write) ? s.cmd : '0;

         if (ctrl_in.advance_or_load)
         begin
            next_s.step = next_step;
            if (s.burst_live)
            begin
               next_s.cmd.valid   = 1'b1;
               next_s.cmd.write   = s.burst_write;
               next_s.cmd.addr    = {s.burst_base[sram_port_pkg::ADDR_W-1:2],
                                     burst_low(s.burst_base[1:0], next_step, s.order)};
               next_s.cmd.lanes_n = ctrl_in.lane_write_sel_n;
            end
            else
            begin
               next_s.cmd = '0;
            end
         end
         else if (selected)
         begin
            next_s.burst_live  = 1'b1;
            next_s.burst_write = ~ctrl_in.write_sel_n;
            next_s.burst_base  = ctrl_in.addr;
            next_s.step        = 2'h0;
            next_s.cmd.valid   = 1'b1;
            next_s.cmd.write   = ~ctrl_in.write_sel_n;
            next_s.cmd.addr    = ctrl_in.addr;
            next_s.cmd.lanes_n = ctrl_in.lane_write_sel_n;
         end
         else
         begin
            next_s.burst_live = 1'b0;
            next_s.cmd        = '0;
         end
      end

      if (next_s.power == sram_port_pkg::PWR_ASLEEP)
      begin
         next_s.cmd        = '0;
         next_s.wr         = '0;
         next_s.drive      = 1'b0;
         next_s.burst_live = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s <= sram_port_pkg::STATE_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign data_out   = s.dout;
   assign asleep_out = s.asleep;

   assign data_oe_out = s.drive & ~out_drive_en_n_in;

endmodule

`default_nettype wire

// ===== shared/sram_port_pkg.sv
// Constants and carrier types for the pipelined burst SRAM port.
// Assumes one synchronous clock domain and the wide four-lane organisation.
package sram_port_pkg;

   localparam int ADDR_W     = 19;
   localparam int LANE_COUNT = 4;
   localparam int LANE_W     = 9;
   localparam int DATA_W     = LANE_COUNT * LANE_W;
   localparam int DEPTH      = 1 << ADDR_W;

   localparam logic [1:0] SLEEP_ENTRY_CYCLES = 2'h2;
   localparam logic [1:0] BURST_STEP_ONE     = 2'h1;
   localparam logic       ORDER_LINEAR       = 1'h0;
   localparam logic       ORDER_INTERLEAVED  = 1'h1;

   typedef enum logic [1:0] {
      PWR_AWAKE,
      PWR_ENTERING,
      PWR_ASLEEP
   } power_t;

   typedef struct packed {
      logic                  chip_sel_first_n;
      logic                  chip_sel_second;
      logic                  chip_sel_third_n;
      logic                  write_sel_n;
      logic                  advance_or_load;
      logic                  clk_qualify_n;
      logic [LANE_COUNT-1:0] lane_write_sel_n;
      logic [ADDR_W-1:0]     addr;
   } ctrl_t;

   typedef struct packed {
      logic                  valid;
      logic                  write;
      logic [ADDR_W-1:0]     addr;
      logic [LANE_COUNT-1:0] lanes_n;
   } stage_t;

   typedef struct packed {
      power_t            power;
      logic [1:0]        sleep_cnt;
      logic              asleep;
      logic              order;
      logic              order_taken;
      logic              burst_live;
      logic              burst_write;
      logic [ADDR_W-1:0] burst_base;
      logic [1:0]        step;
      stage_t            cmd;
      stage_t            wr;
      logic              drive;
      logic [DATA_W-1:0] dout;
   } state_t;

   localparam state_t STATE_RESET = '0;

endpackage

// ===== sim/ctrl_bus_model.sv
// Bus side of the memory controller: resolves the shared data lines.
// Assumes the bench raises host_en_in only while the device floats.
`timescale 1ns/1ps
`default_nettype none

module ctrl_bus_model
(
   input  wire logic                             clk_in,
   input  wire logic [sram_port_pkg::DATA_W-1:0] dev_data_in,
   input  wire logic                             dev_oe_in,
   input  wire logic [sram_port_pkg::DATA_W-1:0] host_data_in,
   input  wire logic                             host_en_in,
   output logic      [sram_port_pkg::DATA_W-1:0] bus_out
);
   logic [sram_port_pkg::DATA_W-1:0] last = '0;
   assign bus_out = (dev_oe_in && host_en_in) ? 'x :
                    dev_oe_in ? dev_data_in : host_en_in ? host_data_in : ~last;
   always_ff @(posedge clk_in)
   begin
      last <= bus_out;
   end
endmodule
`default_nettype wire

// ===== sim/sram_port_checker.sv
// Concurrent checks on the ports of the burst SRAM port.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module sram_port_checker
(
   input wire logic                             clk_in,
   input wire logic                             rst_in,
   input wire sram_port_pkg::ctrl_t             ctrl_in,
   input wire logic                             out_drive_en_n_in,
   input wire logic                             sleep_request_in,
   input wire logic [sram_port_pkg::DATA_W-1:0] data_out,
   input wire logic                             data_oe_out,
   input wire logic                             asleep_out
);
   logic q;
   logic sel;
   logic ld;
   assign q   = !ctrl_in.clk_qualify_n && !sleep_request_in && !asleep_out;
   assign sel = !ctrl_in.chip_sel_first_n && ctrl_in.chip_sel_second && !ctrl_in.chip_sel_third_n;
   assign ld  = q && !ctrl_in.advance_or_load;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   AST_READ_DRIVE: assert property (
      ld && sel && ctrl_in.write_sel_n ##1 q |=> out_drive_en_n_in || data_oe_out)
      else $error("read not driven");
   AST_WRITE_FLOAT: assert property (
      ld && sel && !ctrl_in.write_sel_n ##1 q |=> !data_oe_out) else $error("write not floated");
   AST_DESEL_FLOAT: assert property (
      ld && !sel ##1 q |=> !data_oe_out) else $error("deselect not floated");
   AST_STALL_HOLD: assert property (
      ctrl_in.clk_qualify_n && !sleep_request_in && !asleep_out |=> $stable(data_out))
      else $error("stalled edge moved data");
   AST_OE_MASK: assert property (
      out_drive_en_n_in |-> !data_oe_out) else $error("drive with enable off");
   AST_SLEEP_ENTER: assert property (
      sleep_request_in [*3] |=> asleep_out) else $error("sleep not entered");
   AST_SLEEP_FLOAT: assert property (
      asleep_out |-> !data_oe_out) else $error("drive while asleep");
   AST_WAKE: assert property (
      !sleep_request_in |=> !asleep_out) else $error("sleep not left");
   cover property (ld && sel && ctrl_in.write_sel_n);
   cover property (ld && sel && !ctrl_in.write_sel_n);
   cover property (asleep_out);
endmodule

bind sram_port sram_port_checker u_sram_port_checker
(
   .clk_in            (clk_in),
   .rst_in            (rst_in),
   .ctrl_in           (ctrl_in),
   .out_drive_en_n_in (out_drive_en_n_in),
   .sleep_request_in  (sleep_request_in),
   .data_out          (data_out),
   .data_oe_out       (data_oe_out),
   .asleep_out        (asleep_out)
);
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the burst SRAM port.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam int DW = sram_port_pkg::DATA_W;
   typedef struct packed {logic [18:0] a; logic [3:0] ln; logic [DW-1:0] d, e;} row_t;
   logic                 clk_in      = 1'b0;
   logic                 rst_in      = 1'b1;
   sram_port_pkg::ctrl_t ctrl        = '1;
   logic                 oe_n        = 1'b0;
   logic                 order       = 1'b0;
   logic                 sleep       = 1'b0;
   logic                 host_en     = 1'b0;
   logic [DW-1:0]        host_data   = '0;
   logic [DW-1:0]        bus;
   logic [DW-1:0]        dout;
   logic                 oe;
   logic                 asleep;
   int                   miscompares = 0;
   int                   cmp_count   = 0;
   int                   cycles      = 0;
   row_t rows [7] = '{'{19'h5, 4'h0, 36'h0, 36'h0}, '{19'h5, 4'h5, '1, 36'hFF803FE00},
      '{19'h8, 4'h0, 36'h100, 36'h100}, '{19'h9, 4'h0, 36'h101, 36'h101},
      '{19'hA, 4'h0, 36'h102, 36'h102}, '{19'hB, 4'h0, 36'h103, 36'h103},
      '{19'h8, 4'hF, 36'h0, 36'h100}};

   sram_port u_sram_port
   (
      .clk_in            (clk_in),
      .rst_in            (rst_in),
      .ctrl_in           (ctrl),
      .out_drive_en_n_in (oe_n),
      .burst_order_in    (order),
      .sleep_request_in  (sleep),
      .data_in           (bus),
      .data_out          (dout),
      .data_oe_out       (oe),
      .asleep_out        (asleep)
   );
   ctrl_bus_model u_ctrl_bus_model
   (
      .clk_in       (clk_in),
      .dev_data_in  (dout),
      .dev_oe_in    (oe),
      .host_data_in (host_data),
      .host_en_in   (host_en),
      .bus_out      (bus)
   );

   ////////////////////////////////////////////////////////////////////////////
   always #4 clk_in = ~clk_in;

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic check(input string n, input logic [DW-1:0] s, input logic [DW-1:0] e);
      cmp_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic op(input logic s, w, v, st, input logic [3:0] ln, input logic [18:0] a);
      @(posedge clk_in);
      #1;
      ctrl = '{!s, s, !s, w, v, st, ln, a};
   endtask

   task automatic idle();
      op(1'b0, 1'b1, 1'b0, 1'b0, 4'hF, 19'h0);
   endtask

   task automatic rd(input logic [18:0] a, input logic [DW-1:0] e);
      op(1'b1, 1'b1, 1'b0, 1'b0, 4'hF, a);
      repeat (2) idle();
      check("rdata", dout, e);
      check("rdrive", oe, 1'b1);
   endtask

   task automatic wr(input logic [18:0] a, input logic [3:0] ln, input logic [DW-1:0] d);
      op(1'b1, 1'b0, 1'b0, 1'b0, ln, a);
      repeat (2) idle();
      check("wfloat", oe, 1'b0);
      host_data = d;
      host_en = 1'b1;
      idle();
      host_en = 1'b0;
   endtask

   initial
   begin
      repeat (5) @(posedge clk_in);
      #1;
      rst_in = 1'b0;
      check("rst", {oe, asleep}, 2'h0);
      check("rst_dout", dout, '0);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].ln, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      for (int o = 0; o < 2; o++)
      begin
         rst_in = 1'b1;
         order = o[0];
         @(posedge clk_in);
         #1;
         rst_in = 1'b0;
         check("rst_oe", oe, 1'b0);
         op(1'b1, 1'b1, 1'b0, 1'b0, 4'hF, 19'h9);
         for (int i = 1; i < 6; i++)
         begin
            logic [1:0] k;
            k = i[1:0] - 2'h2;
            op(1'b0, 1'b1, i != 4, 1'b0, 4'hF, 19'h0);
            if (i > 1)
               check("burst", dout, {34'h40, order ? 2'h1 ^ k : 2'h1 + k});
         end
      end
      op(1'b1, 1'b1, 1'b0, 1'b0, 4'hF, 19'h8);
      idle();
      repeat (2) op(1'b0, 1'b1, 1'b0, 1'b1, 4'hF, 19'h0);
      check("stall_oe", oe, 1'b1);
      check("stall_data", dout, 36'h100);
      oe_n = 1'b1;
      #1 check("mask", oe, 1'b0);
      oe_n = 1'b0;
      repeat (2) idle();
      check("desel", oe, 1'b0);
      sleep = 1'b1;
      repeat (3) idle();
      check("asleep", asleep, 1'b1);
      sleep = 1'b0;
      idle();
      check("awake", asleep, 1'b0);
      repeat (2) idle();
      rd(19'hA, 36'h102);
      op(1'b1, 1'b0, 1'b0, 1'b0, 4'hE, 19'h8);
      op(1'b0, 1'b1, 1'b1, 1'b0, 4'h7, 19'h0);
      idle();
      host_data = '1;
      host_en = 1'b1;
      idle();
      @(posedge clk_in);
      #1;
      host_en = 1'b0;
      rd(19'h8, 36'h1FF);
      rd(19'h9, 36'hFF8000101);
      give_verdict();
   end
endmodule
`default_nettype wire
